// ---- inc/ssl_pkg.sv ----
// package of constants and types for the synthesizer serial load port
package ssl_pkg;
    // serial word layout: address first, then data
    localparam int ADDR_W = 4;
    localparam int DATA_W = 12;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_WORD = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ADDR = 5'h04;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
    localparam logic [CNT_W-1:0] SMP_MIN = 5'h02;
    localparam logic [CNT_W-1:0] SMP_MAX = 5'h0c;
    // serial register addresses
    localparam logic [ADDR_W-1:0] SADR_PDCP = 4'h5;
    localparam logic [ADDR_W-1:0] SADR_MUX = 4'h6;
    localparam logic [ADDR_W-1:0] SADR_MODCTL = 4'h7;
    localparam logic [ADDR_W-1:0] SADR_MODDATA = 4'h8;
    // field positions inside serial registers
    localparam int MUX_SEL_LO = 6;
    localparam int MUX_SEL_HI = 8;
    localparam int MUX_TRI_BIT = 9;
    localparam int MOD_INSEL_BIT = 4;
    localparam int MOD_ADIS_BIT = 5;
    localparam int PDCP_MSTEER_BIT = 10;
    localparam int PDCP_ASTEER_BIT = 11;
    localparam logic [DATA_W-1:0] SREG_RST = 12'h000;
    // output multiplexer codes
    localparam logic [2:0] MUX_OSC = 3'h0;
    localparam logic [2:0] MUX_REF_AUX = 3'h1;
    localparam logic [2:0] MUX_REF_MAIN = 3'h2;
    localparam logic [2:0] MUX_PD_AUX = 3'h3;
    localparam logic [2:0] MUX_PD_MAIN = 3'h4;
    localparam logic [2:0] MUX_SER = 3'h5;
    localparam logic [2:0] MUX_TEST = 3'h6;
    // wishbone byte offsets
    localparam logic [7:0] WB_STATUS = 8'h00;
    localparam logic [7:0] WB_MASK = 8'h04;
    localparam logic [7:0] WB_LAST = 8'h08;
    localparam logic [7:0] WB_SAMPLE = 8'h0c;
    localparam logic [7:0] WB_IDX = 8'h10;
    localparam logic [7:0] WB_SHADOW = 8'h14;
    localparam logic [7:0] WB_CTRL = 8'h18;
    // status bits
    localparam int EV_W = 3;
    localparam int EV_WORD = 0;
    localparam int EV_SAMPLE = 1;
    localparam int EV_DROP = 2;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    localparam logic CTRL_EN_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } ssl_st_e;

    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic sdata;
        logic mod_in;
    } ssl_pins_s;

    typedef struct packed {
        logic osc;
        logic ref_aux;
        logic ref_main;
        logic pd_aux;
        logic pd_main;
        logic test;
    } ssl_taps_s;

    typedef struct packed {
        logic locked;
        logic pulse;
        logic steer;
    } ssl_loop_s;
endpackage

// ---- hw/ssl_sync.sv ----
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module ssl_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // ssl_sync

// ---- hw/ssl_top.sv ----
// serial load port with wishbone status, mux output and lock pins
`timescale 1ns/1ps
module ssl_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire ssl_pkg::ssl_pins_s pins_i,
    input wire ssl_pkg::ssl_taps_s taps_i,
    input wire ssl_pkg::ssl_loop_s main_loop_i,
    input wire ssl_pkg::ssl_loop_s aux_loop_i,
    output logic mux_out_o,
    output logic mux_out_oe_o,
    output logic main_lock_or_steer_out_o,
    output logic main_lock_or_steer_out_oe_o,
    output logic aux_lock_or_steer_out_o,
    output logic aux_lock_or_steer_out_oe_o,
    output logic cfg_valid_o,
    output logic [ssl_pkg::ADDR_W-1:0] cfg_addr_o,
    output logic [ssl_pkg::DATA_W-1:0] cfg_data_o,
    output logic smp_valid_o,
    output logic [ssl_pkg::DATA_W-1:0] smp_o,
    output logic [ssl_pkg::CNT_W-1:0] smp_len_o
);
    localparam int NREG = 2 ** ssl_pkg::ADDR_W;

    typedef struct packed {
        ssl_pkg::ssl_st_e st;
        logic sclk;
        logic sel_n;
        logic [ssl_pkg::WORD_W-1:0] sh;
        logic [ssl_pkg::WORD_W-1:0] msh;
        logic [ssl_pkg::CNT_W-1:0] cnt;
        logic [NREG-1:0][ssl_pkg::DATA_W-1:0] sreg;
        logic [ssl_pkg::EV_W-1:0] status;
        logic [ssl_pkg::EV_W-1:0] mask;
        logic port_en;
        logic [ssl_pkg::ADDR_W-1:0] idx;
        logic ack;
        logic [31:0] rdata;
        logic cfg_v;
        logic [ssl_pkg::ADDR_W-1:0] cfg_addr;
        logic [ssl_pkg::DATA_W-1:0] cfg_data;
        logic [ssl_pkg::CNT_W-1:0] last_cnt;
        logic smp_v;
        logic [ssl_pkg::DATA_W-1:0] smp;
        logic [ssl_pkg::CNT_W-1:0] smp_len;
        logic mux;
        logic mux_oe;
        logic mlk;
        logic mlk_oe;
        logic alk;
        logic alk_oe;
    } ssl_top_s;

    ssl_top_s q_q;
    ssl_top_s q_d;
    ssl_pkg::ssl_pins_s pin_s;

    ssl_sync #(
        .WIDTH(4),
        .RST_VAL(4'h4)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_i),
        .q_o(pin_s)
    );

    // decoded settings from the serially loaded registers
    logic [2:0] mux_sel;
    logic mux_tri;
    logic in_sel;
    logic adr_dis;
    logic msteer;
    logic asteer;
    assign mux_sel = q_q.sreg[ssl_pkg::SADR_MUX]
        [ssl_pkg::MUX_SEL_HI:ssl_pkg::MUX_SEL_LO];
    assign mux_tri = q_q.sreg[ssl_pkg::SADR_MUX][ssl_pkg::MUX_TRI_BIT];
    assign in_sel = q_q.sreg[ssl_pkg::SADR_MODCTL][ssl_pkg::MOD_INSEL_BIT];
    assign adr_dis = q_q.sreg[ssl_pkg::SADR_MODCTL][ssl_pkg::MOD_ADIS_BIT];
    assign msteer = q_q.sreg[ssl_pkg::SADR_PDCP][ssl_pkg::PDCP_MSTEER_BIT];
    assign asteer = q_q.sreg[ssl_pkg::SADR_PDCP][ssl_pkg::PDCP_ASTEER_BIT];

    logic sclk_rise;
    logic sel_fall;
    logic sel_rise;
    logic is_smp_len;
    assign sclk_rise = pin_s.sclk & ~q_q.sclk;
    assign sel_fall = ~pin_s.sel_n & q_q.sel_n & q_q.port_en;
    assign sel_rise = pin_s.sel_n & ~q_q.sel_n;
    assign is_smp_len = q_q.cnt >= ssl_pkg::SMP_MIN
        && q_q.cnt <= ssl_pkg::SMP_MAX;

    logic wb_req;
    logic wb_wr;
    assign wb_req = cyc_i & stb_i & ~q_q.ack;
    assign wb_wr = wb_req & we_i & sel_i[0];

    always_comb begin
        logic [ssl_pkg::EV_W-1:0] ev;
        logic [ssl_pkg::WORD_W-1:0] src;
        ev = '0;
        src = '0;
        q_d = q_q;
        q_d.sclk = pin_s.sclk;
        q_d.sel_n = pin_s.sel_n;
        q_d.cfg_v = 1'b0;
        q_d.smp_v = 1'b0;
        unique case (q_q.st)
            ssl_pkg::ST_IDLE: begin
                // clock edges while select is high do nothing
                if (sel_fall) begin
                    q_d.st = ssl_pkg::ST_SHIFT;
                    q_d.cnt = '0;
                end
            end
            ssl_pkg::ST_SHIFT: begin
                if (sel_rise) begin
                    q_d.st = ssl_pkg::ST_IDLE;
                    q_d.last_cnt = q_q.cnt;
                    src = in_sel ? q_q.msh : q_q.sh;
                    if (q_q.cnt == ssl_pkg::CNT_WORD) begin
                        // address sits in the first bits shifted
                        q_d.sreg[q_q.sh[ssl_pkg::WORD_W-1:ssl_pkg::DATA_W]] =
                            q_q.sh[ssl_pkg::DATA_W-1:0];
                        q_d.cfg_v = 1'b1;
                        q_d.cfg_addr = q_q.sh[ssl_pkg::WORD_W-1:ssl_pkg::DATA_W];
                        q_d.cfg_data = q_q.sh[ssl_pkg::DATA_W-1:0];
                        ev[ssl_pkg::EV_WORD] = 1'b1;
                    end
                    if (adr_dis && is_smp_len) begin
                        q_d.smp_v = 1'b1;
                        // older frames' bits must not leak into short samples
                        q_d.smp = src[ssl_pkg::DATA_W-1:0]
                            & ~({ssl_pkg::DATA_W{1'b1}} << q_q.cnt);
                        q_d.smp_len = q_q.cnt;
                        ev[ssl_pkg::EV_SAMPLE] = 1'b1;
                    end else if (!adr_dis && in_sel
                        && q_q.cnt == ssl_pkg::CNT_WORD
                        && q_q.msh[ssl_pkg::WORD_W-1:ssl_pkg::DATA_W]
                        == ssl_pkg::SADR_MODDATA) begin
                        q_d.smp_v = 1'b1;
                        q_d.smp = q_q.msh[ssl_pkg::DATA_W-1:0];
                        q_d.smp_len = ssl_pkg::CNT_W'(ssl_pkg::DATA_W);
                        ev[ssl_pkg::EV_SAMPLE] = 1'b1;
                    end else if (q_q.cnt != ssl_pkg::CNT_WORD) begin
                        // short or odd transfers are thrown away
                        ev[ssl_pkg::EV_DROP] = 1'b1;
                    end
                end else if (sclk_rise && !pin_s.sel_n) begin
                    q_d.sh = {q_q.sh[ssl_pkg::WORD_W-2:0], pin_s.sdata};
                    q_d.msh = {q_q.msh[ssl_pkg::WORD_W-2:0], pin_s.mod_in};
                    if (q_q.cnt != ssl_pkg::CNT_MAX) begin
                        q_d.cnt = q_q.cnt + 1'b1;
                    end
                end
            end
        endcase

        // output multiplexer, registered so the pin is glitch free
        unique case (mux_sel)
            ssl_pkg::MUX_OSC: q_d.mux = taps_i.osc;
            ssl_pkg::MUX_REF_AUX: q_d.mux = taps_i.ref_aux;
            ssl_pkg::MUX_REF_MAIN: q_d.mux = taps_i.ref_main;
            ssl_pkg::MUX_PD_AUX: q_d.mux = taps_i.pd_aux;
            ssl_pkg::MUX_PD_MAIN: q_d.mux = taps_i.pd_main;
            ssl_pkg::MUX_SER: q_d.mux = q_q.sh[ssl_pkg::WORD_W-1];
            ssl_pkg::MUX_TEST: q_d.mux = taps_i.test;
            default: q_d.mux = 1'b0;
        endcase
        q_d.mux_oe = ~mux_tri;

        // open collector lock pins, or driven steering
        if (msteer) begin
            q_d.mlk = main_loop_i.steer;
            q_d.mlk_oe = 1'b1;
        end else begin
            q_d.mlk = 1'b0;
            q_d.mlk_oe = ~main_loop_i.locked & main_loop_i.pulse;
        end
        if (asteer) begin
            q_d.alk = aux_loop_i.steer;
            q_d.alk_oe = 1'b1;
        end else begin
            q_d.alk = 1'b0;
            q_d.alk_oe = ~aux_loop_i.locked & aux_loop_i.pulse;
        end

        // wishbone slave, one wait state, unmapped reads return zero
        q_d.ack = wb_req;
        q_d.rdata = '0;
        if (wb_req && !we_i) begin
            unique case (adr_i)
                ssl_pkg::WB_STATUS: q_d.rdata[ssl_pkg::EV_W-1:0] = q_q.status;
                ssl_pkg::WB_MASK: q_d.rdata[ssl_pkg::EV_W-1:0] = q_q.mask;
                ssl_pkg::WB_LAST: q_d.rdata[20:0] =
                    {q_q.last_cnt, q_q.cfg_addr, q_q.cfg_data};
                ssl_pkg::WB_SAMPLE: q_d.rdata[16:0] = {q_q.smp_len, q_q.smp};
                ssl_pkg::WB_IDX: q_d.rdata[ssl_pkg::ADDR_W-1:0] = q_q.idx;
                ssl_pkg::WB_SHADOW: q_d.rdata[ssl_pkg::DATA_W-1:0] =
                    q_q.sreg[q_q.idx];
                ssl_pkg::WB_CTRL: q_d.rdata[0] = q_q.port_en;
                default: q_d.rdata = '0;
            endcase
        end
        if (wb_wr) begin
            unique case (adr_i)
                ssl_pkg::WB_MASK: q_d.mask = dat_i[ssl_pkg::EV_W-1:0];
                ssl_pkg::WB_IDX: q_d.idx = dat_i[ssl_pkg::ADDR_W-1:0];
                ssl_pkg::WB_CTRL: q_d.port_en = dat_i[0];
                default: ;
            endcase
        end
        // write one to clear, a new event in the same cycle wins
        if (wb_wr && adr_i == ssl_pkg::WB_STATUS) begin
            q_d.status = q_q.status & ~dat_i[ssl_pkg::EV_W-1:0];
        end
        q_d.status = q_d.status | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_q <= '0;
            q_q.st <= ssl_pkg::ST_IDLE;
            q_q.sel_n <= 1'b1;
            q_q.sreg <= {NREG{ssl_pkg::SREG_RST}};
            q_q.mask <= ssl_pkg::MASK_RST;
            q_q.port_en <= ssl_pkg::CTRL_EN_RST;
            q_q.mux_oe <= 1'b1;
        end else begin
            q_q <= q_d;
        end
    end

    assign dat_o = q_q.rdata;
    assign ack_o = q_q.ack;
    assign irq_o = |(q_q.status & q_q.mask);
    assign mux_out_o = q_q.mux;
    assign mux_out_oe_o = q_q.mux_oe;
    assign main_lock_or_steer_out_o = q_q.mlk;
    assign main_lock_or_steer_out_oe_o = q_q.mlk_oe;
    assign aux_lock_or_steer_out_o = q_q.alk;
    assign aux_lock_or_steer_out_oe_o = q_q.alk_oe;
    assign cfg_valid_o = q_q.cfg_v;
    assign cfg_addr_o = q_q.cfg_addr;
    assign cfg_data_o = q_q.cfg_data;
    assign smp_valid_o = q_q.smp_v;
    assign smp_o = q_q.smp;
    assign smp_len_o = q_q.smp_len;

    chk_shift_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (q_q.st == ssl_pkg::ST_SHIFT && !sel_rise && sclk_rise
            && !pin_s.sel_n && q_q.cnt != ssl_pkg::CNT_MAX)
        |=> q_q.cnt == $past(q_q.cnt) + 1'b1
            && q_q.sh[0] == $past(pin_s.sdata))
        else $error("serial bit not shifted");

    chk_idle_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        (q_q.st == ssl_pkg::ST_IDLE) |=> $stable(q_q.sh) && $stable(q_q.msh))
        else $error("shift while select high");

    chk_commit_word: assert property (@(posedge clk_i) disable iff (rst_i)
        (q_q.st == ssl_pkg::ST_SHIFT && sel_rise
            && q_q.cnt == ssl_pkg::CNT_WORD)
        |=> cfg_valid_o ##1 !cfg_valid_o
            && q_q.sreg[q_q.cfg_addr] == q_q.cfg_data)
        else $error("word not committed");

    chk_partial_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        (q_q.st == ssl_pkg::ST_SHIFT && sel_rise
            && q_q.cnt < ssl_pkg::CNT_ADDR && !(adr_dis && is_smp_len))
        |=> !cfg_valid_o && $stable(q_q.sreg) && q_q.status[ssl_pkg::EV_DROP])
        else $error("partial transfer changed registers");

    chk_mux_tri: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(mux_tri) |=> mux_out_oe_o == !$past(mux_tri))
        else $error("mux tri-state wrong");

    chk_mux_serial: assert property (@(posedge clk_i) disable iff (rst_i)
        (mux_sel == ssl_pkg::MUX_SER) |=> mux_out_o == $past(q_q.sh[15]))
        else $error("mux serial loop-back wrong");

    chk_main_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (!msteer && main_loop_i.locked) |=> !main_lock_or_steer_out_oe_o)
        else $error("main lock pin driven while locked");

    chk_main_steer: assert property (@(posedge clk_i) disable iff (rst_i)
        (msteer && main_loop_i.steer)
        |=> main_lock_or_steer_out_oe_o && main_lock_or_steer_out_o)
        else $error("main steering not driven");

    chk_aux_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (!asteer && !aux_loop_i.locked && aux_loop_i.pulse)
        |=> aux_lock_or_steer_out_oe_o && !aux_lock_or_steer_out_o)
        else $error("aux out-of-lock pulse missing");

    chk_sample_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (q_q.st == ssl_pkg::ST_SHIFT && sel_rise && adr_dis && is_smp_len)
        |=> smp_valid_o && smp_len_o == $past(q_q.cnt))
        else $error("modulation sample not taken");
endmodule // ssl_top

// ---- sim/ssl_host_model.sv ----
// serial host model driving select, link clock and both data pins
`timescale 1ns/1ps
module ssl_host_model (
    input wire logic clk_i,
    output ssl_pkg::ssl_pins_s pins_o
);
    logic busy;

    initial begin
        pins_o = '{sclk: 1'b0, sel_n: 1'b1, sdata: 1'b0, mod_in: 1'b1};
        busy = 1'b0;
    end

    // data lines have no pull: keep them moving between frames
    always @(posedge clk_i) begin
        if (!busy) begin
            pins_o.sdata <= ~pins_o.sdata;
            pins_o.mod_in <= ~pins_o.mod_in;
        end
    end

    // half of a 160 ns link clock period
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask

    // n bits, msb first; link clock idles low outside frames
    task automatic frame(input int n, input logic [15:0] d,
                         input logic [15:0] m);
        @(posedge clk_i);
        busy <= 1'b1;
        @(posedge clk_i);
        pins_o.sel_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            pins_o.sdata <= d[i];
            pins_o.mod_in <= m[i];
            half();
            pins_o.sclk <= 1'b1;
            half();
            pins_o.sclk <= 1'b0;
        end
        half();
        pins_o.sel_n <= 1'b1;
        busy <= 1'b0;
        half();
    endtask

    // clock pulses with select high, which the port must ignore
    task automatic stray();
        repeat (3) begin
            half();
            pins_o.sclk <= 1'b1;
            half();
            pins_o.sclk <= 1'b0;
        end
    endtask
endmodule // ssl_host_model

// ---- sim/ssl_top_tb_top.sv ----
// self-checking bench for the serial load port
`timescale 1ns/1ps
module ssl_top_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] dout;
    logic [31:0] rdat;
    logic ack, irq, mux, mux_oe, m_out, m_oe, a_out, a_oe, cfg_v, smp_v;
    logic [3:0] cfg_a;
    logic [3:0] lk;
    logic [11:0] cfg_d, smp;
    logic [4:0] smp_len;
    ssl_pkg::ssl_pins_s pins;
    ssl_pkg::ssl_taps_s taps = '0;
    ssl_pkg::ssl_loop_s ml = '0;
    ssl_pkg::ssl_loop_s al = '0;
    int n_errors = 0;
    int checks = 0;
    int n_cfg = 0;
    int n_smp = 0;
    integer seed = 32'h0000_14f8;

    assign lk = {m_out, m_oe, a_out, a_oe};

    ssl_top ssl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(dout), .ack_o(ack), .irq_o(irq), .pins_i(pins),
        .taps_i(taps), .main_loop_i(ml), .aux_loop_i(al), .mux_out_o(mux),
        .mux_out_oe_o(mux_oe), .main_lock_or_steer_out_o(m_out),
        .main_lock_or_steer_out_oe_o(m_oe), .aux_lock_or_steer_out_o(a_out),
        .aux_lock_or_steer_out_oe_o(a_oe), .cfg_valid_o(cfg_v),
        .cfg_addr_o(cfg_a), .cfg_data_o(cfg_d), .smp_valid_o(smp_v),
        .smp_o(smp), .smp_len_o(smp_len));

    ssl_host_model ssl_host_model_inst (.clk_i(clk_i), .pins_o(pins));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (cfg_v === 1'b1) n_cfg++;
        if (smp_v === 1'b1) n_smp++;
    end

    task automatic chk(input logic [31:0] got, exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        // a missing answer is a failure, not a silent skip
        if (ack !== 1'b1) begin
            n_errors++;
        end
        r = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string msg);
        logic [31:0] r;
        wb(1'b0, a, 32'h0000_0000, r);
        chk(r, e, msg);
    endtask

    // whole 16-bit word: address nibble then 12 data bits
    task automatic sw(input logic [3:0] a, input logic [11:0] d);
        ssl_host_model_inst.frame(16, {a, d}, {4'h0, ~d});
        repeat (8) @(posedge clk_i);
    endtask

    function automatic logic mux_exp(input logic [2:0] c,
                                     input ssl_pkg::ssl_taps_s t);
        case (c)
            ssl_pkg::MUX_OSC: return t.osc;
            ssl_pkg::MUX_REF_AUX: return t.ref_aux;
            ssl_pkg::MUX_REF_MAIN: return t.ref_main;
            ssl_pkg::MUX_PD_AUX: return t.pd_aux;
            ssl_pkg::MUX_PD_MAIN: return t.pd_main;
            ssl_pkg::MUX_TEST: return t.test;
            default: return 1'b0;
        endcase
    endfunction

    // {pin value, pin enable}; lock mode only pulls low, never drives high
    function automatic logic [1:0] le(input logic st,
                                      input ssl_pkg::ssl_loop_s l);
        return st ? {l.steer, 1'b1} : {1'b0, ~l.locked & l.pulse};
    endfunction

    task automatic end_of_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end

    initial begin
        logic [11:0] d, v, ws;
        logic [15:0] w16;
        logic [2:0] c;
        logic [3:0] e4;
        int n, m;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(ssl_pkg::WB_STATUS, 32'h0000_0000, "status rst");
        rd(ssl_pkg::WB_CTRL, 32'h0000_0001, "ctrl rst");
        chk(32'({irq, mux_oe, m_oe, a_oe}), 32'h0000_0004, "pins");
        wb(1'b1, 8'h1c, 32'hffff_ffff, rdat);
        rd(8'h1c, 32'h0000_0000, "unmapped");
        wb(1'b1, ssl_pkg::WB_MASK, 32'h0000_0007, rdat);
        wb(1'b1, ssl_pkg::WB_IDX, 32'h0000_0006, rdat);
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            d = (12'($random(seed)) & 12'hc3f) | {3'h0, c, 6'h00};
            w16 = {ssl_pkg::SADR_MUX, d};
            sw(ssl_pkg::SADR_MUX, d);
            chk(32'({cfg_a, cfg_d}), 32'({4'h6, d}), "cfg");
            rd(ssl_pkg::WB_SHADOW, 32'(d), "shadow");
            chk(32'(irq), 32'h0000_0001, "irq set");
            wb(1'b1, ssl_pkg::WB_STATUS, 32'h0000_0007, rdat);
            repeat (2) @(posedge clk_i);
            chk(32'(irq), 32'h0000_0000, "irq clear");
            repeat (3) begin
                taps <= ssl_pkg::ssl_taps_s'(6'($random(seed)));
                repeat (2) @(posedge clk_i);
                // loop-back shows the first bit of the last word shifted
                e4 = {2'b00, 1'b1,
                      (c == ssl_pkg::MUX_SER) ? w16[15] : mux_exp(c, taps)};
                chk(32'({mux_oe, mux}), 32'(e4), "mux");
            end
        end
        sw(ssl_pkg::SADR_MUX, 12'h200);
        chk(32'(mux_oe), 32'h0000_0000, "tri");
        wb(1'b1, ssl_pkg::WB_STATUS, 32'h0000_0007, rdat);
        wb(1'b1, ssl_pkg::WB_MASK, 32'h0000_0003, rdat);
        n = n_cfg;
        ssl_host_model_inst.frame(3, 16'h0005, 16'h0000);
        ssl_host_model_inst.stray();
        repeat (8) @(posedge clk_i);
        chk(32'(n_cfg), 32'(n), "no commit");
        rd(ssl_pkg::WB_SHADOW, 32'h0000_0200, "kept");
        rd(ssl_pkg::WB_STATUS, 32'h0000_0004, "drop");
        rd(ssl_pkg::WB_LAST, 32'({5'h03, 4'h6, 12'h200}), "cnt");
        chk(32'(irq), 32'h0000_0000, "masked");
        // port disabled: a full word must not start a frame
        wb(1'b1, ssl_pkg::WB_CTRL, 32'h0000_0000, rdat);
        sw(ssl_pkg::SADR_MUX, 12'h000);
        chk(32'(n_cfg), 32'(n), "port off");
        wb(1'b1, ssl_pkg::WB_CTRL, 32'h0000_0001, rdat);
        for (int k = 0; k < 4; k++) begin
            sw(ssl_pkg::SADR_PDCP, {k[1:0], 10'h000});
            repeat (4) begin
                ml <= ssl_pkg::ssl_loop_s'(3'($random(seed)));
                al <= ssl_pkg::ssl_loop_s'(3'($random(seed)));
                repeat (2) @(posedge clk_i);
                e4 = {le(k[0], ml), le(k[1], al)};
                chk(32'(lk), 32'(e4), "lock");
            end
        end
        for (int s = 0; s < 2; s++) begin
            sw(ssl_pkg::SADR_MODCTL, {6'h00, 1'b1, s[0], 4'h0});
            for (int k = 0; k < 3; k++) begin
                n = (k == 0) ? 2 : (k == 1) ? 12 : 2 + {$random(seed)} % 11;
                v = 12'($random(seed)) & 12'((1 << n) - 1);
                ws = 12'($random(seed));
                m = n_smp;
                ssl_host_model_inst.frame(n, 16'(s ? ws : v), 16'(s ? v : ws));
                repeat (8) @(posedge clk_i);
                chk(32'(n_smp), 32'(m + 1), "smp count");
                chk(32'({smp_len, smp}), 32'({5'(n), v}), "smp");
            end
        end
        sw(ssl_pkg::SADR_MODCTL, 12'h010);
        m = n_smp;
        v = 12'($random(seed));
        ssl_host_model_inst.frame(16, 16'h0000, {ssl_pkg::SADR_MODDATA, v});
        repeat (8) @(posedge clk_i);
        chk(32'(n_smp), 32'(m + 1), "mod word");
        chk(32'(smp), 32'(v), "mod data");
        rd(ssl_pkg::WB_LAST, 32'({5'h10, 16'h0000}), "last");
        rd(ssl_pkg::WB_SAMPLE, 32'({5'h0c, v}), "sample");
        end_of_test();
    end
endmodule // ssl_top_tb_top
